// File: hw/pcg_clk_switch.sv
`timescale 1ns/100ps
module pcg_clk_switch #(
    parameter int HOLD_CYCLES = pcg_pkg::PCG_SWITCH_HOLD
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic sel_vco,
    input  wire logic x_rise,
    input  wire logic v_rise,
    input  wire logic v_run,
    output logic      base_clk,
    output logic      switching
);
    import pcg_pkg::*;

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 3) begin : g_bad_hold
        $error("HOLD_CYCLES must lie in 1..3");
    end

    localparam logic [1:0] HOLD = 2'(HOLD_CYCLES);

    typedef struct packed {
        logic       cur;
        logic [1:0] cnt_x;
        logic [1:0] cnt_v;
        logic       out;
    } pcg_sw_t;

    pcg_sw_t st;
    pcg_sw_t next_st;

    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st = '0;
        end else if (sel_vco != st.cur) begin
            // Output frozen while the crystal and, if running, the VCO settle
            if (x_rise && st.cnt_x != HOLD) next_st.cnt_x = st.cnt_x + 2'h1;
            if (v_rise && st.cnt_v != HOLD) next_st.cnt_v = st.cnt_v + 2'h1;
            if (st.cnt_x == HOLD && (st.cnt_v == HOLD || !v_run)) begin
                next_st.cur   = sel_vco;
                next_st.cnt_x = 2'h0;
                next_st.cnt_v = 2'h0;
            end
        end else if (st.cur ? v_rise : x_rise) begin
            next_st.out = ~st.out;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else        st <= next_st;
    end

    assign base_clk  = st.out;
    assign switching = (st.cur != sel_vco);

endmodule : pcg_clk_switch

// File: hw/pcg_clock_gen.sv
// How it works
// [R1] Interrupt enable is write-locked and reads zero in manual mode; reset clears.
// [R2] Any lock change sets the flag; flag with enable raises interrupt.
// [R3] Every read of the control register clears the lock-change flag; a lock change in the same cycle leaves it set.
// [R4] Flag reads zero in manual mode; reset clears it.
// [R5] Power-on bit resets set; clearing refused while base select is set.
// [R6] Base select cannot be set while the loop is powered off.
// [R7] After select changes, output holds for three cycles of each running source.
// [R8] Base clock is selected source halved; one means VCO, zero crystal.
// [R9] Reset and stop both clear the base select bit.
// [R10] Low four control bits always read back as ones.
// [R11] Bandwidth bit: one automatic, zero manual; reset clears.
// [R12] Lock bit follows detector in automatic mode, zero in manual.
// [R13] Acquisition bit is status in automatic, control in manual; resets zero.
// [R14] Manual acquisition value kept hidden during automatic mode, then restored.
// [R15] Writing one starts crystal test; later read shows one if lost.
// [R16] Crystal test works only with VCO selected, else reads zero.
// [R17] Software writes zeros to the bandwidth test bits.
// [R18] Multiplier field, zero treated as one, resets to six.
// [R19] Multiplier and range writes ignored while loop is powered.
// [R20] Range resets six; zero disables loop and forces crystal source.
// [R21] Software checks lock after interrupt and before selecting VCO.
// [R22] Oscillator enable low stops the clocks, crystal on resume; only clocks, interrupt and loop power go low, registers stay live.
// [R23] Interrupt is a level while flag and enable both set.
`timescale 1ns/100ps
module pcg_clock_gen (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       crystal_tick,
    input  wire logic       vco_tick,
    input  wire logic       lock_detect_in,
    input  wire logic       track_detect_in,
    input  wire logic       oscillator_enable_in,
    input  wire logic       stop_exec,
    output logic            crystal_clock,
    output logic            vco_clock,
    output logic            base_clock_out,
    output logic            clockgen_interrupt,
    output logic            loop_power_on,
    output logic            auto_bandwidth,
    output logic            tracking_select,
    output logic      [3:0] feedback_multiplier,
    output logic      [3:0] vco_range_multiplier
);
    import pcg_pkg::*;

    typedef struct packed {
        logic       lock_irq_enable;
        logic       lock_change_flag;
        logic       loop_on;
        logic       base_clock_select;
        logic       auto_mode;
        logic       lock_state;
        logic       acq_manual;
        logic [3:0] mult;
        logic [3:0] range;
        logic       xclk;
        logic       vclk;
        logic [7:0] rdata;
        logic       irq;
        logic       pwr;
        logic       track;
        logic [3:0] mult_out;
        logic [3:0] range_out;
    } pcg_state_t;

    pcg_state_t st;
    pcg_state_t next_st;

    logic       osc_en;
    logic       range_ok;
    logic       vco_run;
    logic       x_rise;
    logic       v_rise;
    logic       wr_ctl;
    logic       wr_bw;
    logic       wr_ppg;
    logic       rd_ctl;
    logic       acq_view;
    logic       xld_start;
    logic       xld_lost;
    logic       base_clk;
    logic       switching;
    logic [7:0] ctl_view;
    logic [7:0] bw_view;
    logic [7:0] ppg_view;

    assign osc_en   = oscillator_enable_in;
    assign range_ok = (st.range != 4'h0);
    // Loop only runs when powered, range legal and oscillator enabled
    assign vco_run  = st.loop_on && range_ok && osc_en;
    assign x_rise   = osc_en && crystal_tick && !st.xclk;
    assign v_rise   = vco_run && vco_tick && !st.vclk;

    assign wr_ctl = reg_wr && (reg_addr == PCG_OFS_CONTROL);
    assign wr_bw  = reg_wr && (reg_addr == PCG_OFS_BANDWIDTH);
    assign wr_ppg = reg_wr && (reg_addr == PCG_OFS_PROGRAM);
    assign rd_ctl = reg_rd && (reg_addr == PCG_OFS_CONTROL);

    // [R13] status or control
    assign acq_view = st.auto_mode ? track_detect_in : st.acq_manual;

    // [R15] test starts on a one written
    assign xld_start = wr_bw && reg_wdata[PCG_BW_XLD_BIT];

    // [R1] [R4] [R10] control read view
    always_comb begin
        ctl_view                   = {4'h0, PCG_CTL_LOW_FILL};
        ctl_view[PCG_CTL_IE_BIT]   = st.auto_mode && st.lock_irq_enable;
        ctl_view[PCG_CTL_FLAG_BIT] = st.auto_mode && st.lock_change_flag;
        ctl_view[PCG_CTL_ON_BIT]   = st.loop_on;
        ctl_view[PCG_CTL_BCS_BIT]  = st.base_clock_select;
    end

    // [R12] [R16] bandwidth read view
    always_comb begin
        bw_view                  = {4'h0, PCG_BW_LOW_FILL};
        bw_view[PCG_BW_AUTO_BIT] = st.auto_mode;
        bw_view[PCG_BW_LOCK_BIT] = st.auto_mode && st.lock_state;
        bw_view[PCG_BW_ACQ_BIT]  = acq_view;
        bw_view[PCG_BW_XLD_BIT]  = st.base_clock_select && xld_lost;
    end

    always_comb begin
        ppg_view = 8'h00;
        ppg_view[PCG_PPG_MUL_LSB +: 4] = st.mult;
        ppg_view[PCG_PPG_VRS_LSB +: 4] = st.range;
    end

    always_comb begin
        next_st = st;

        // Register read data, valid in the cycle after the strobe only
        next_st.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                PCG_OFS_CONTROL:   next_st.rdata = ctl_view;
                PCG_OFS_BANDWIDTH: next_st.rdata = bw_view;
                PCG_OFS_PROGRAM:   next_st.rdata = ppg_view;
                default:           next_st.rdata = 8'h00;
            endcase
        end

        // Control register write
        if (wr_ctl) begin
            // [R1] enable locked in manual
            if (st.auto_mode) begin
                next_st.lock_irq_enable = reg_wdata[PCG_CTL_IE_BIT];
            end
            // [R5] clear refused under select
            if (reg_wdata[PCG_CTL_ON_BIT] || !st.base_clock_select) begin
                next_st.loop_on = reg_wdata[PCG_CTL_ON_BIT];
            end
            // [R6] [R20] select needs loop already on
            if (!reg_wdata[PCG_CTL_BCS_BIT]) begin
                next_st.base_clock_select = 1'b0;
            end else if (st.loop_on && range_ok) begin
                next_st.base_clock_select = 1'b1;
            end
        end

        // [R11] [R14] bandwidth write; hidden copy kept in automatic mode
        if (wr_bw) begin
            next_st.auto_mode = reg_wdata[PCG_BW_AUTO_BIT];
            if (!st.auto_mode) begin
                next_st.acq_manual = reg_wdata[PCG_BW_ACQ_BIT];
            end
        end

        // [R19] programming frozen while powered
        if (wr_ppg && !st.loop_on) begin
            next_st.mult  = reg_wdata[PCG_PPG_MUL_LSB +: 4];
            next_st.range = reg_wdata[PCG_PPG_VRS_LSB +: 4];
        end

        // [R20] zero range forces crystal source
        if (!range_ok) begin
            next_st.base_clock_select = 1'b0;
        end

        // [R9] [R22] stop returns to crystal
        if (stop_exec || !osc_en) begin
            next_st.base_clock_select = 1'b0;
        end

        // [R12] lock only meaningful in automatic mode
        next_st.lock_state = st.auto_mode ? lock_detect_in : 1'b0;

        // [R3] read clears flag; [R2] a change in the same cycle wins
        if (rd_ctl) begin
            next_st.lock_change_flag = 1'b0;
        end
        // [R2] [R4] set on every lock toggle
        if (st.auto_mode && next_st.lock_state != st.lock_state) begin
            next_st.lock_change_flag = 1'b1;
        end
        // [R4] flag and enable dropped in manual mode
        if (!st.auto_mode) begin
            next_st.lock_change_flag = 1'b0;
            next_st.lock_irq_enable  = 1'b0;
        end

        // [R22] source clocks halted while oscillator disabled
        if (!osc_en) begin
            next_st.xclk = 1'b0;
        end else if (crystal_tick) begin
            next_st.xclk = ~st.xclk;
        end
        if (!vco_run) begin
            next_st.vclk = 1'b0;
        end else if (vco_tick) begin
            next_st.vclk = ~st.vclk;
        end

        // [R23] [R22] level request, held low in stop
        next_st.irq = osc_en && st.auto_mode && st.lock_irq_enable
                      && next_st.lock_change_flag;

        // Analog controls
        next_st.pwr       = vco_run;
        next_st.track     = acq_view;
        // [R18] zero multiplier treated as one
        next_st.mult_out  = pcg_eff_mult(st.mult);
        next_st.range_out = st.range;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.loop_on   <= PCG_RST_ON;
            st.mult      <= PCG_RST_MUL;
            st.range     <= PCG_RST_VRS;
            st.mult_out  <= PCG_RST_MUL;
            st.range_out <= PCG_RST_VRS;
        end else begin
            st <= next_st;
        end
    end

    // [R7] [R8] glitch-free halving switch
    pcg_clk_switch #(
        .HOLD_CYCLES (PCG_SWITCH_HOLD)
    ) u_switch (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .enable    (osc_en),
        .sel_vco   (st.base_clock_select),
        .x_rise    (x_rise),
        .v_rise    (v_rise),
        .v_run     (vco_run),
        .base_clk  (base_clk),
        .switching (switching)
    );

    // [R15] [R16] crystal loss test
    pcg_xtal_loss #(
        .FACTOR (PCG_XLD_FACTOR)
    ) u_xloss (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .armed   (st.base_clock_select),
        .start   (xld_start),
        .x_rise  (x_rise),
        .v_rise  (v_rise),
        .mult    (st.mult),
        .lost    (xld_lost)
    );

    assign reg_rdata            = st.rdata;
    assign crystal_clock        = st.xclk;
    assign vco_clock            = st.vclk;
    assign base_clock_out       = base_clk;
    assign clockgen_interrupt   = st.irq;
    assign loop_power_on        = st.pwr;
    assign auto_bandwidth       = st.auto_mode;
    assign tracking_select      = st.track;
    assign feedback_multiplier  = st.mult_out;
    assign vco_range_multiplier = st.range_out;

endmodule : pcg_clock_gen

// File: hw/pcg_pkg.sv
package pcg_pkg;

    // Register indices on the two-bit register port
    localparam logic [1:0] PCG_OFS_CONTROL   = 2'h0;
    localparam logic [1:0] PCG_OFS_BANDWIDTH = 2'h1;
    localparam logic [1:0] PCG_OFS_PROGRAM   = 2'h2;

    // Control register fields
    localparam int PCG_CTL_IE_BIT   = 7;
    localparam int PCG_CTL_FLAG_BIT = 6;
    localparam int PCG_CTL_ON_BIT   = 5;
    localparam int PCG_CTL_BCS_BIT  = 4;
    localparam logic [3:0] PCG_CTL_LOW_FILL = 4'hF;

    // Bandwidth register fields
    localparam int PCG_BW_AUTO_BIT  = 7;
    localparam int PCG_BW_LOCK_BIT  = 6;
    localparam int PCG_BW_ACQ_BIT   = 5;
    localparam int PCG_BW_XLD_BIT   = 4;
    localparam logic [3:0] PCG_BW_LOW_FILL = 4'h0;

    // Programming register fields
    localparam int PCG_PPG_MUL_LSB = 4;
    localparam int PCG_PPG_VRS_LSB = 0;

    // Reset values
    localparam logic       PCG_RST_ON   = 1'b1;
    localparam logic [3:0] PCG_RST_MUL  = 4'h6;
    localparam logic [3:0] PCG_RST_VRS  = 4'h6;

    // Timing counts, in source clock cycles
    localparam int PCG_SWITCH_HOLD = 3;
    localparam int PCG_XLD_FACTOR  = 4;

    // Field value zero behaves as a multiplier of one
    function automatic logic [3:0] pcg_eff_mult(input logic [3:0] field);
        pcg_eff_mult = (field == 4'h0) ? 4'h1 : field;
    endfunction : pcg_eff_mult

endpackage : pcg_pkg

// File: hw/pcg_xtal_loss.sv
`timescale 1ns/100ps
module pcg_xtal_loss #(
    parameter int FACTOR = pcg_pkg::PCG_XLD_FACTOR
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       armed,
    input  wire logic       start,
    input  wire logic       x_rise,
    input  wire logic       v_rise,
    input  wire logic [3:0] mult,
    output logic            lost
);
    import pcg_pkg::*;

    if (FACTOR < 1 || FACTOR > 4) begin : g_bad_factor
        $error("FACTOR must lie in 1..4");
    end

    typedef struct packed {
        logic       flag;
        logic       active;
        logic [5:0] cnt;
    } pcg_xl_t;

    pcg_xl_t    st;
    pcg_xl_t    next_st;
    logic [5:0] window;

    always_comb begin
        window  = 6'(FACTOR) * {2'h0, pcg_eff_mult(mult)};
        next_st = st;
        if (!armed) begin
            next_st = '0;
        end else if (start) begin
            next_st.flag   = 1'b1;
            next_st.active = 1'b1;
            next_st.cnt    = 6'h00;
        end else if (st.active) begin
            // Any crystal rising edge inside the window proves it alive
            if (x_rise) next_st.flag = 1'b0;
            if (v_rise) next_st.cnt = st.cnt + 6'h01;
            if (v_rise && st.cnt + 6'h01 >= window) next_st.active = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) st <= '0;
        else        st <= next_st;
    end

    assign lost = st.flag;

endmodule : pcg_xtal_loss

// File: tb/pcg_clock_gen_chk.sv
`timescale 1ns/100ps
module pcg_clock_gen_chk (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] reg_addr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       crystal_tick,
    input  wire logic       lock_detect_in,
    input  wire logic       oscillator_enable_in,
    input  wire logic       crystal_clock,
    input  wire logic       base_clock_out,
    input  wire logic       clockgen_interrupt,
    input  wire logic       loop_power_on,
    input  wire logic       auto_bandwidth,
    input  wire logic [3:0] feedback_multiplier,
    input  wire logic [3:0] vco_range_multiplier
);
    import pcg_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_ctl_low_ones: assert property ($past(reg_rd) && $past(reg_addr) == PCG_OFS_CONTROL
        |-> reg_rdata[3:0] == 4'hF)
        else $error("control low bits not ones");
    a_ctl_manual_zero: assert property ($past(reg_rd) && !$past(auto_bandwidth)
        && $past(reg_addr) == PCG_OFS_CONTROL |-> reg_rdata[7:6] == 2'h0)
        else $error("enable or flag visible in manual mode");
    a_bw_manual_lock: assert property ($past(reg_rd) && !$past(auto_bandwidth)
        && $past(reg_addr) == PCG_OFS_BANDWIDTH |-> !reg_rdata[6])
        else $error("lock visible in manual mode");
    a_irq_read_clear: assert property (clockgen_interrupt && reg_rd
        && reg_addr == PCG_OFS_CONTROL && $stable(lock_detect_in)
        && $past(lock_detect_in, 2) == lock_detect_in |-> ##[1:3] !clockgen_interrupt)
        else $error("interrupt stays after control read");
    a_prog_locked: assert property ($changed(vco_range_multiplier)
        || $changed(feedback_multiplier) |-> !loop_power_on)
        else $error("programming changed while loop on");
    a_mult_nonzero: assert property (feedback_multiplier != 4'h0)
        else $error("multiplier of zero");
    a_range_zero_off: assert property (vco_range_multiplier == 4'h0 |=> !loop_power_on)
        else $error("loop on with zero range");
    a_stop_quiet: assert property (!oscillator_enable_in [*3]
        |-> !crystal_clock && !base_clock_out && !clockgen_interrupt)
        else $error("outputs active in stop");
    a_xclk_toggle: assert property (oscillator_enable_in [*2] ##0 crystal_tick
        |=> crystal_clock != $past(crystal_clock))
        else $error("crystal clock missed a tick");

    c_irq: cover property ($rose(clockgen_interrupt));
    c_read_clear: cover property ($fell(clockgen_interrupt) && $past(reg_rd));
    c_stop: cover property (!oscillator_enable_in [*3]);
endmodule : pcg_clock_gen_chk

bind pcg_clock_gen pcg_clock_gen_chk u_chk (.ref_clk, .rst_n, .reg_addr, .reg_rd,
    .reg_rdata, .crystal_tick, .lock_detect_in, .oscillator_enable_in, .crystal_clock,
    .base_clock_out, .clockgen_interrupt, .loop_power_on, .auto_bandwidth,
    .feedback_multiplier, .vco_range_multiplier);

// File: tb/pcg_clock_gen_test.sv
`timescale 1ns/100ps
module pcg_clock_gen_test;
    import pcg_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst_n   = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       stop_exec = 1'b0;
    logic       xtal_on = 1'b1;
    logic       lock_req = 1'b0;
    logic       osc_req = 1'b1;
    logic [7:0] reg_rdata;
    logic       crystal_tick;
    logic       vco_tick;
    logic       lock_detect_in;
    logic       track_detect_in;
    logic       oscillator_enable_in;
    logic       crystal_clock;
    logic       base_clock_out;
    logic       clockgen_interrupt;
    logic       loop_power_on;
    logic       tracking_select;
    logic [3:0] feedback_multiplier;
    int         fails = 0;
    int         checked = 0;
    int         cyc = 0;

    always #25 ref_clk = ~ref_clk;

    pcg_far_model u_far (.ref_clk, .xtal_on, .lock_req, .osc_req, .crystal_tick, .vco_tick,
        .lock_detect_in, .track_detect_in, .oscillator_enable_in);

    pcg_clock_gen DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .crystal_tick, .vco_tick, .lock_detect_in, .track_detect_in, .oscillator_enable_in,
        .stop_exec, .crystal_clock, .vco_clock(), .base_clock_out, .clockgen_interrupt,
        .loop_power_on, .auto_bandwidth(), .tracking_select, .feedback_multiplier,
        .vco_range_multiplier());

    task automatic end_of_test;
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string nm);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Mask hides bits whose value this check does not judge
    task automatic rd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e,
                      input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(e, reg_rdata & m, nm);
    endtask : rd

    // Window of 120 cycles; one change of slack for phase
    task automatic rate(input int lo, input int hi, input string nm);
        int   n;
        logic b;
        n = 0;
        b = base_clock_out;
        repeat (120) begin
            @(posedge ref_clk);
            #1;
            if (base_clock_out !== b) n++;
            b = base_clock_out;
        end
        checked++;
        if (n < lo || n > hi) begin
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
            fails++;
        end
    endtask : rate

    task automatic t_reset;
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h2F, "ctl_reset");
        rd(PCG_OFS_BANDWIDTH, 8'hFF, 8'h00, "bw_reset");
        rd(PCG_OFS_PROGRAM, 8'hFF, 8'h66, "ppg_reset");
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'hFF, 8'h00, "unmapped");
    endtask : t_reset

    task automatic t_manual;
        wr(PCG_OFS_CONTROL, 8'hE0);
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h2F, "ie_locked");
        wr(PCG_OFS_BANDWIDTH, 8'h20);
        rd(PCG_OFS_BANDWIDTH, 8'hFF, 8'h20, "acq_write");
        chk(8'h01, {7'h0, tracking_select}, "track_out");
        lock_req <= 1'b1;
        rd(PCG_OFS_BANDWIDTH, 8'h40, 8'h00, "lock_manual");
        lock_req <= 1'b0;
    endtask : t_manual

    task automatic t_select;
        wr(PCG_OFS_CONTROL, 8'h00);
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h0F, "power_off");
        wr(PCG_OFS_CONTROL, 8'h30);
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h2F, "bcs_refused");
        rate(9, 11, "xtal_rate");
        wr(PCG_OFS_CONTROL, 8'h30);
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h3F, "bcs_set");
        wr(PCG_OFS_CONTROL, 8'h10);
        rd(PCG_OFS_CONTROL, 8'hFF, 8'h3F, "off_refused");
        wt(60);
        rate(29, 31, "vco_rate");
        wr(PCG_OFS_PROGRAM, 8'h35);
        rd(PCG_OFS_PROGRAM, 8'hFF, 8'h66, "ppg_locked");
    endtask : t_select

    task automatic t_xld;
        wr(PCG_OFS_BANDWIDTH, 8'h10); // test bits written as zero
        wt(150);
        rd(PCG_OFS_BANDWIDTH, 8'h10, 8'h00, "xtal_alive");
        xtal_on <= 1'b0;
        wr(PCG_OFS_BANDWIDTH, 8'h10);
        wt(150);
        rd(PCG_OFS_BANDWIDTH, 8'h10, 8'h10, "xtal_lost");
        xtal_on <= 1'b1;
    endtask : t_xld

    task automatic t_stop;
        @(posedge ref_clk);
        stop_exec <= 1'b1;
        @(posedge ref_clk);
        stop_exec <= 1'b0;
        rd(PCG_OFS_CONTROL, 8'h10, 8'h00, "stop_bcs");
        rd(PCG_OFS_BANDWIDTH, 8'h10, 8'h00, "xld_idle");
        wt(60);
        rate(9, 11, "stop_rate");
        osc_req <= 1'b0;
        wt(10);
        chk(8'h00, {6'h0, crystal_clock, base_clock_out}, "stop_clocks");
        osc_req <= 1'b1;
        wt(10);
        rd(PCG_OFS_CONTROL, 8'h10, 8'h00, "resume_bcs");
    endtask : t_stop

    task automatic t_prog;
        wr(PCG_OFS_CONTROL, 8'h00);
        wr(PCG_OFS_PROGRAM, 8'h05);
        rd(PCG_OFS_PROGRAM, 8'hFF, 8'h05, "ppg_write");
        chk(8'h01, {4'h0, feedback_multiplier}, "mult_zero");
        wr(PCG_OFS_PROGRAM, 8'h30);
        wr(PCG_OFS_CONTROL, 8'h20);
        wt(3);
        chk(8'h00, {7'h0, loop_power_on}, "range_off");
        wr(PCG_OFS_CONTROL, 8'h30);
        rd(PCG_OFS_CONTROL, 8'h10, 8'h00, "range_bcs");
        wr(PCG_OFS_CONTROL, 8'h00);
        wr(PCG_OFS_PROGRAM, 8'h66);
    endtask : t_prog

    task automatic t_auto;
        wr(PCG_OFS_BANDWIDTH, 8'hA0); // tracking stored before automatic
        wr(PCG_OFS_CONTROL, 8'hA0);
        lock_req <= 1'b1;
        wt(10);
        chk(8'h01, {7'h0, clockgen_interrupt}, "irq_rise");
        chk(8'h01, {7'h0, tracking_select}, "acq_status");
        rd(PCG_OFS_CONTROL, 8'hC0, 8'hC0, "ie_flag");
        wt(3);
        chk(8'h00, {7'h0, clockgen_interrupt}, "irq_clear");
        lock_req <= 1'b0;
        wt(10);
        chk(8'h01, {7'h0, clockgen_interrupt}, "irq_unlock");
        rd(PCG_OFS_BANDWIDTH, 8'hC0, 8'h80, "bw_unlock");
        rd(PCG_OFS_CONTROL, 8'h40, 8'h40, "flag_set");
        rd(PCG_OFS_CONTROL, 8'h40, 8'h00, "flag_gone");
        wr(PCG_OFS_BANDWIDTH, 8'h00);
        rd(PCG_OFS_CONTROL, 8'hC0, 8'h00, "manual_ctl");
        rd(PCG_OFS_BANDWIDTH, 8'h20, 8'h20, "acq_restore");
    endtask : t_auto

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_of_test();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_manual();
        t_select();
        t_xld();
        t_stop();
        t_prog();
        t_auto();
        end_of_test();
    end
endmodule : pcg_clock_gen_test

// File: tb/pcg_far_model.sv
`timescale 1ns/100ps
module pcg_far_model #(
    parameter int XP = 6,
    parameter int VP = 2
) (
    input  wire logic ref_clk,
    input  wire logic xtal_on,
    input  wire logic lock_req,
    input  wire logic osc_req,
    output logic      crystal_tick,
    output logic      vco_tick,
    output logic      lock_detect_in,
    output logic      track_detect_in,
    output logic      oscillator_enable_in
);
    int xc = 0;
    int vc = 0;
    always @(posedge ref_clk) begin
        xc <= (xc == XP - 1) ? 0 : xc + 1;
        vc <= (vc == VP - 1) ? 0 : vc + 1;
        crystal_tick <= xtal_on && (xc == 0);
        vco_tick <= (vc == 0);
    end
    assign lock_detect_in  = lock_req;
    assign track_detect_in = lock_req;
    assign oscillator_enable_in = osc_req;
endmodule : pcg_far_model
